// ===== rtl/ccp_csr_file.sv
// Purpose: Control/status registers behind the CPU bus
// Assumes: Index is CPU address bits 10 down to 2
// Notes: Unmapped offsets read zero and drop writes
`timescale 1ns/1ns
`include "ccp_map.svh"
module ccp_csr_file (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_we,
  input wire logic [8:0] i_idx,
  input wire logic [31:0] i_wdata,
  input wire logic [31:0] i_status,
  output logic [31:0] o_rdata,
  output logic o_refresh_en
);
  logic [31:0] ctrl;

  // Writes land only on the control word; others vanish without error
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      ctrl <= `CCP_CTRL_RESET;
      o_rdata <= '0;
    end else begin
      if (i_we && i_idx == `CCP_CSR_CTRL) begin
        ctrl <= i_wdata;
      end
      case (i_idx)
        `CCP_CSR_CTRL: o_rdata <= ctrl;
        `CCP_CSR_STAT: o_rdata <= i_status;
        default: o_rdata <= '0;
      endcase
    end
  end

  assign o_refresh_en = ctrl[`CCP_CTRL_REFRESH_EN];
endmodule // ccp_csr_file

// ===== rtl/ccp_fifo.sv
// Purpose: Word FIFO with a registered read stage
// Assumes: One clock, synchronous active low reset
// Notes: Depth comes from a byte size; ready and valid are registers
`timescale 1ns/1ns
`include "ccp_map.svh"
module ccp_fifo #(
  parameter int BYTES = 256,
  parameter int WIDTH = 32
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_wr_valid,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_wr_ready,
  input wire logic i_rd_ready,
  output logic o_rd_valid,
  output logic [WIDTH-1:0] o_rd_data
);
  localparam int DEPTH = BYTES / `CCP_WORD_BYTES;
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  logic [AW:0] next_count;
  logic next_valid;

  // Pop into the output register whenever it is empty or being drained
  assign push = i_wr_valid & o_wr_ready;
  assign pop = (count != '0) & (~o_rd_valid | i_rd_ready);
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  // Output register counts toward capacity, so no more than DEPTH words are ever held
  assign next_valid = pop | (o_rd_valid & ~i_rd_ready);

  // Storage has no reset: it is only read behind a valid count
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_wr_data;
    end
  end

  // Pointers, count and the registered handshake outputs
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_wr_ready <= 1'b0;
      o_rd_valid <= 1'b0;
      o_rd_data <= '0;
    end else begin
      count <= next_count;
      o_wr_ready <= (next_count + (AW+1)'(next_valid)) != (AW+1)'(DEPTH); // Full stalls the source
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
        o_rd_data <= mem[rd_ptr];
        o_rd_valid <= 1'b1;
      end else if (i_rd_ready) begin
        o_rd_valid <= 1'b0;
      end
    end
  end
endmodule // ccp_fifo

// ===== rtl/ccp_front.sv
// Purpose: CPU bus front end: clock stretch, CSR access, SDRAM precharge/mode set
// Assumes: CPU pins are asynchronous to i_core_clk; refresh request is same-domain
// Notes: The CPU clock is made here by a divider, so it is no second domain
`timescale 1ns/1ns
`include "ccp_map.svh"
module ccp_front #(
  parameter int DIV_HALF = `CCP_DIV_HALF
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire ccp_pkg::ccp_cpu_in_t i_cpu,
  input wire logic i_refresh_req,
  output logic o_cpu_stretched_clock,
  output logic [31:0] o_cpu_data,
  output logic o_cpu_data_oe,
  output ccp_pkg::ccp_sdram_t o_sdram,
  input wire ccp_pkg::ccp_word_t i_ob_push,
  output logic o_ob_ready,
  input wire logic i_ob_pop_ready,
  output ccp_pkg::ccp_word_t o_ob_pop,
  input wire ccp_pkg::ccp_word_t i_ib_push,
  output logic o_ib_ready,
  input wire logic i_ib_pop_ready,
  output ccp_pkg::ccp_word_t o_ib_pop,
  input wire ccp_pkg::ccp_word_t i_rf_push,
  output logic o_rf_ready,
  input wire logic i_rf_pop_ready,
  output ccp_pkg::ccp_word_t o_rf_pop
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Idle bus: no chip selected, masks follow the release counter
  function automatic ccp_pkg::ccp_sdram_t ccp_nop(input logic [3:0] mask);
    ccp_pkg::ccp_sdram_t c;
    c = '0;
    c.cs_n = 4'hF;
    c.ras_n = 1'b1;
    c.cas_n = 1'b1;
    c.we_n = 1'b1;
    c.byte_mask = mask;
    return c;
  endfunction

  // One command cycle with the given strobes and address fields
  function automatic ccp_pkg::ccp_sdram_t ccp_cmd(input logic [3:0] cs_n, input logic cas_n,
                                                  input logic we_n, input logic [1:0] bank,
                                                  input logic [12:0] mux, input logic [3:0] mask);
    ccp_pkg::ccp_sdram_t c;
    c.cs_n = cs_n;
    c.ras_n = 1'b0;
    c.cas_n = cas_n;
    c.we_n = we_n;
    c.bank = bank;
    c.mux_addr = mux;
    c.byte_mask = mask;
    return c;
  endfunction

  // Region of a CPU address
  function automatic ccp_pkg::ccp_kind_t ccp_kind(input logic [31:0] a);
    ccp_pkg::ccp_kind_t k;
    k = ccp_pkg::CCP_KIND_OTHER;
    if (a[`CCP_REGION_HI:`CCP_REGION_LO] == `CCP_CSR_REGION) begin
      k = ccp_pkg::CCP_KIND_CSR;
    end else if (a[`CCP_REGION_HI:`CCP_REGION_LO] == `CCP_MODE_REGION) begin
      k = ccp_pkg::CCP_KIND_MODE;
    end
    return k;
  endfunction

  // Chip select, active low, for one array
  function automatic logic [3:0] ccp_sel_n(input logic [1:0] arr);
    return ~(4'h1 << arr);
  endfunction

  // Masks stay high until enough qualifying commands have gone out
  function automatic logic [3:0] ccp_mask(input logic [2:0] cnt);
    return (cnt < `CCP_MASK_RELEASE) ? `CCP_MASK_ALL : `CCP_MASK_NONE;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  ccp_pkg::ccp_front_state_t s;
  ccp_pkg::ccp_front_state_t next_s;
  logic [31:0] csr_rdata;
  logic refresh_en;
  logic tick;
  logic hold;
  logic req;
  logic issue;
  logic [31:0] status;
  ccp_pkg::ccp_kind_t kind;
  logic [1:0] arr;

  assign req = ~s.s2.mreq_n;
  assign kind = ccp_kind(s.s2.addr);
  assign arr = s.addr[`CCP_ARRAY_HI:`CCP_ARRAY_LO];
  assign status = {29'h0, s.mask_cnt};

  // ****************************************************************
  // Control/status registers
  // ****************************************************************
  ccp_csr_file u_csr (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_we(s.csr_we),
    .i_idx(s.addr[`CCP_CSR_IDX_HI:`CCP_CSR_IDX_LO]),
    .i_wdata(s.s2.wdata),
    .i_status(status),
    .o_rdata(csr_rdata),
    .o_refresh_en(refresh_en)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************

  // Divider makes the CPU clock; high phase is held while an access is open
  always_comb begin
    next_s = s;
    next_s.s1 = i_cpu;
    next_s.s2 = s.s1;
    next_s.csr_we = 1'b0;
    next_s.sd = ccp_nop(ccp_mask(s.mask_cnt));
    issue = 1'b0;
    tick = s.div == 8'(DIV_HALF - 1);
    next_s.div = tick ? 8'h00 : s.div + 8'h01;
    hold = (s.st == ccp_pkg::CCP_ACCESS) || (s.st == ccp_pkg::CCP_CMD)
           || (s.st == ccp_pkg::CCP_IDLE && req);
    if (tick) begin
      if (!s.clk_hi) begin
        next_s.clk_hi = 1'b1;
      end else if (!hold) begin
        next_s.clk_hi = 1'b0;
      end
    end
    case (s.st)
      ccp_pkg::CCP_IDLE: begin
        if (req && s.clk_hi) begin
          // Latch the cycle and choose its stall length by region
          next_s.addr = s.s2.addr;
          next_s.wr = s.s2.write;
          next_s.kind = kind;
          next_s.st = ccp_pkg::CCP_ACCESS;
          case (kind)
            ccp_pkg::CCP_KIND_CSR: begin
              next_s.stall = 8'(`CCP_CSR_STALL * 2 - 1);
              next_s.csr_we = s.s2.write;
            end
            ccp_pkg::CCP_KIND_MODE: next_s.stall = 8'h00;
            default: next_s.stall = 8'(`CCP_OTHER_STALL * 2 - 1);
          endcase
        end else if (s.ref_pend) begin
          // Refresh goes to every array only while the bus is free
          next_s.sd = ccp_cmd(4'h0, 1'b0, 1'b1, 2'h0, 13'h0000, ccp_mask(s.mask_cnt));
          issue = 1'b1;
        end
      end
      ccp_pkg::CCP_ACCESS: begin
        if (tick) begin
          if (s.stall != 8'h00) begin
            next_s.stall = s.stall - 8'h01;
          end else if (s.kind == ccp_pkg::CCP_KIND_MODE) begin
            // One command cycle, then keep the CPU stalled while it settles
            issue = 1'b1;
            next_s.st = ccp_pkg::CCP_CMD;
            next_s.stall = 8'(`CCP_CMD_STALL * 2 - 1);
            if (s.wr) begin
              next_s.sd = ccp_cmd(ccp_sel_n(arr), 1'b0, 1'b0, 2'h0,
                                  {6'h00, s.addr[`CCP_MRS_HI:`CCP_MRS_LO]},
                                  ccp_mask(s.mask_cnt));
            end else begin
              next_s.sd = ccp_cmd(ccp_sel_n(arr), 1'b1, 1'b0, `CCP_PRE_BA,
                                  {`CCP_PRE_MA_HI, 8'h00}, ccp_mask(s.mask_cnt));
            end
          end else begin
            // CSR read data comes from the registered file; others read zero
            next_s.st = ccp_pkg::CCP_RELEASE;
            next_s.oe = ~s.wr;
            next_s.rdata = (s.kind == ccp_pkg::CCP_KIND_CSR) ? csr_rdata : 32'h0000_0000;
          end
        end
      end
      ccp_pkg::CCP_CMD: begin
        if (tick) begin
          if (s.stall != 8'h00) begin
            next_s.stall = s.stall - 8'h01;
          end else begin
            next_s.st = ccp_pkg::CCP_RELEASE;
            next_s.oe = ~s.wr;
            next_s.rdata = 32'h0000_0000;
          end
        end
      end
      ccp_pkg::CCP_RELEASE: begin
        // Data stays driven until the stretched high phase has ended
        if (!s.clk_hi) begin
          next_s.st = ccp_pkg::CCP_IDLE;
          next_s.oe = 1'b0;
        end
      end
      default: begin
        next_s.st = ccp_pkg::CCP_IDLE;
        next_s.oe = 1'b0;
      end
    endcase
    // Refresh request that meets its own issue is kept: set wins
    next_s.ref_pend = (s.ref_pend & ~(issue && s.st == ccp_pkg::CCP_IDLE))
                      | (i_refresh_req & refresh_en);
    if (issue && s.mask_cnt < `CCP_MASK_RELEASE) begin
      next_s.mask_cnt = s.mask_cnt + 3'h1;
    end
    next_s.sd.byte_mask = ccp_mask(next_s.mask_cnt);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************

  // Synchronous reset; masks start high and the CPU clock starts low
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      s <= '0;
      s.s1.mreq_n <= 1'b1;
      s.s2.mreq_n <= 1'b1;
      s.st <= ccp_pkg::CCP_IDLE;
      s.sd.cs_n <= 4'hF;
      s.sd.ras_n <= 1'b1;
      s.sd.cas_n <= 1'b1;
      s.sd.we_n <= 1'b1;
      s.sd.byte_mask <= `CCP_MASK_ALL;
    end else begin
      s <= next_s;
    end
  end

  assign o_cpu_stretched_clock = s.clk_hi;
  assign o_cpu_data = s.rdata;
  assign o_cpu_data_oe = s.oe;
  assign o_sdram = s.sd;

  // ****************************************************************
  // Transaction FIFOs
  // ****************************************************************

  // Outbound: CPU and DMA addresses and write data toward PCI
  ccp_fifo #(.BYTES(`CCP_OB_BYTES), .WIDTH(32)) u_ob (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_wr_valid(i_ob_push.valid),
    .i_wr_data(i_ob_push.data),
    .o_wr_ready(o_ob_ready),
    .i_rd_ready(i_ob_pop_ready),
    .o_rd_valid(o_ob_pop.valid),
    .o_rd_data(o_ob_pop.data)
  );

  // Inbound: PCI writes and reads, DMA data, CPU read data from PCI
  ccp_fifo #(.BYTES(`CCP_IB_BYTES), .WIDTH(32)) u_ib (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_wr_valid(i_ib_push.valid),
    .i_wr_data(i_ib_push.data),
    .o_wr_ready(o_ib_ready),
    .i_rd_ready(i_ib_pop_ready),
    .o_rd_valid(o_ib_pop.valid),
    .o_rd_data(o_ib_pop.data)
  );

  // Read FIFO: SDRAM and ROM data returned to PCI masters
  ccp_fifo #(.BYTES(`CCP_RF_BYTES), .WIDTH(32)) u_rf (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_wr_valid(i_rf_push.valid),
    .i_wr_data(i_rf_push.data),
    .o_wr_ready(o_rf_ready),
    .i_rd_ready(i_rf_pop_ready),
    .o_rd_valid(o_rf_pop.valid),
    .o_rd_data(o_rf_pop.data)
  );

endmodule // ccp_front

// ===== rtl/ccp_map.svh
// Purpose: Address map, field positions and timing counts of the core bus front end
// Assumes: Included by bare name from every file that needs a figure
// Notes: Region codes and CSR offsets are local choices; stall counts are CPU clock cycles
`ifndef CCP_MAP_SVH
`define CCP_MAP_SVH

// ****************************************************************
// Address decode
// ****************************************************************
`define CCP_REGION_HI 31
`define CCP_REGION_LO 24
`define CCP_CSR_REGION 8'h42
`define CCP_MODE_REGION 8'h40
`define CCP_ARRAY_HI 21
`define CCP_ARRAY_LO 20
`define CCP_CSR_IDX_HI 10
`define CCP_CSR_IDX_LO 2
`define CCP_MRS_HI 8
`define CCP_MRS_LO 2

// ****************************************************************
// CSR offsets (word index) and fields
// ****************************************************************
`define CCP_CSR_CTRL 9'h000
`define CCP_CSR_STAT 9'h001
`define CCP_CTRL_RESET 32'h0000_0001
`define CCP_CTRL_REFRESH_EN 0

// ****************************************************************
// Stall lengths in CPU clock cycles
// ****************************************************************
`define CCP_CSR_STALL 8'h03
`define CCP_CMD_STALL 8'h02
`define CCP_OTHER_STALL 8'h01

// ****************************************************************
// SDRAM command fields
// ****************************************************************
`define CCP_PRE_BA 2'h3
`define CCP_PRE_MA_HI 5'h1F
`define CCP_MASK_RELEASE 3'h4
`define CCP_MASK_ALL 4'hF
`define CCP_MASK_NONE 4'h0

// ****************************************************************
// Sizes and clock divider
// ****************************************************************
`define CCP_OB_BYTES 256
`define CCP_IB_BYTES 256
`define CCP_RF_BYTES 128
`define CCP_WORD_BYTES 4
`define CCP_DIV_HALF 4

`endif

// ===== rtl/ccp_pkg.sv
// Purpose: Types shared by the core bus front end
// Assumes: Figures live in ccp_map.svh
// Notes: No imports; users write ccp_pkg::name
package ccp_pkg;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic mreq_n;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ccp_cpu_in_t;

  typedef struct packed {
    logic [3:0] cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bank;
    logic [12:0] mux_addr;
    logic [3:0] byte_mask;
  } ccp_sdram_t;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } ccp_word_t;

  // Gray coded along idle, access, command, release
  typedef enum logic [1:0] {
    CCP_IDLE = 2'h0,
    CCP_ACCESS = 2'h1,
    CCP_CMD = 2'h3,
    CCP_RELEASE = 2'h2
  } ccp_state_t;

  typedef enum logic [1:0] {
    CCP_KIND_OTHER = 2'h0,
    CCP_KIND_CSR = 2'h1,
    CCP_KIND_MODE = 2'h2
  } ccp_kind_t;

  typedef struct packed {
    ccp_cpu_in_t s1;
    ccp_cpu_in_t s2;
    ccp_state_t st;
    ccp_kind_t kind;
    logic clk_hi;
    logic [7:0] div;
    logic [7:0] stall;
    logic [31:0] addr;
    logic wr;
    logic [31:0] rdata;
    logic oe;
    logic csr_we;
    ccp_sdram_t sd;
    logic [2:0] mask_cnt;
    logic ref_pend;
  } ccp_front_state_t;

endpackage

// ===== verif/ccp_cpu_model.sv
// Purpose: Core-side bus master that runs one bus cycle at a time
// Assumes: A request is set up in a low phase and ends when the clock falls
// Notes: Released pins carry the inverse of their last value
`timescale 1ns/1ns
module ccp_cpu_model (
  input wire logic i_core_clk,
  input wire logic i_cpu_clk,
  input wire logic [31:0] i_data,
  input wire logic i_data_oe,
  output ccp_pkg::ccp_cpu_in_t o_cpu
);
  // ********************
  // Bus cycle
  // ********************
  initial o_cpu = {1'b1, 1'b0, 32'h0000_0000, 32'h0000_0000};

  // Bounded wait for a level of the stretched clock
  task automatic wait_lvl(input logic lvl, inout int n);
    while (i_cpu_clk !== lvl && n < 3000) begin
      @(posedge i_core_clk);
      n++;
    end
  endtask

  // Driving at the start of a low phase lets the pin synchroniser settle before the rise
  task automatic bus_cycle(input logic wr, input logic [31:0] a, input logic [31:0] d,
                           output logic [31:0] q, output logic oe);
    int n;
    n = 0;
    @(posedge i_core_clk);
    wait_lvl(1'b1, n);
    wait_lvl(1'b0, n);
    o_cpu <= {1'b0, wr, a, d};
    wait_lvl(1'b1, n);
    wait_lvl(1'b0, n);
    q = i_data;
    oe = i_data_oe;
    o_cpu <= {1'b1, ~wr, ~a, ~d};
  endtask
endmodule // ccp_cpu_model

// ===== verif/ccp_front_assertions.sv
// Purpose: Port-level checks of the core bus front end
// Assumes: Core pins stand from a low phase until the stretched clock falls
// Notes: Stall bounds are minimums, so a longer stall still passes
`timescale 1ns/1ns
`include "ccp_map.svh"
module ccp_front_assertions #(
  parameter int DIV_HALF = 4
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire ccp_pkg::ccp_cpu_in_t i_cpu,
  input wire logic o_cpu_stretched_clock,
  input wire logic [31:0] o_cpu_data,
  input wire logic o_cpu_data_oe,
  input wire ccp_pkg::ccp_sdram_t o_sdram
);
  // ********************
  // Helper logic
  // ********************
  logic [7:0] hi;
  logic [2:0] cnt;
  logic csr;
  wire logic cmd = (o_sdram.cs_n != 4'hF);
  wire logic pre = cmd && !o_sdram.ras_n && o_sdram.cas_n && !o_sdram.we_n;
  wire logic mrs = cmd && !o_sdram.ras_n && !o_sdram.cas_n && !o_sdram.we_n;
  wire logic [3:0] sel = ~(4'h1 << i_cpu.addr[`CCP_ARRAY_HI:`CCP_ARRAY_LO]);
  wire logic in_mode = (i_cpu.addr[`CCP_REGION_HI:`CCP_REGION_LO] == `CCP_MODE_REGION);

  // High-phase length, CSR cycle in this high phase, commands seen (saturates)
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      hi <= 8'h00;
      cnt <= 3'h0;
      csr <= 1'b0;
    end else begin
      hi <= o_cpu_stretched_clock ? hi + 8'h01 : 8'h00;
      csr <= o_cpu_stretched_clock && (csr || (!i_cpu.mreq_n &&
             i_cpu.addr[`CCP_REGION_HI:`CCP_REGION_LO] == `CCP_CSR_REGION));
      if (cmd && cnt != `CCP_MASK_RELEASE) begin
        cnt <= cnt + 3'h1;
      end
    end
  end

  // ********************
  // Properties
  // ********************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_clk_fall;
    $fell(o_cpu_stretched_clock);
  endsequence

  sequence s_csr_read_out;
    $rose(o_cpu_data_oe) ##0 (csr && !i_cpu.write);
  endsequence

  a_clk_min_high: assert property (s_clk_fall |-> hi >= DIV_HALF)
    else $error("stretched clock high phase too short");
  a_csr_stall_len: assert property (s_clk_fall ##0 csr |-> hi >= 6 * DIV_HALF)
    else $error("register access stalled less than three cycles");
  a_unmapped_zero: assert property (s_csr_read_out ##0 (i_cpu.addr[10:2] > 9'h001)
    |-> o_cpu_data == 32'h0000_0000)
    else $error("unmapped register read not zero");
  a_pre_fields: assert property (pre |-> o_sdram.bank == `CCP_PRE_BA &&
    o_sdram.mux_addr[12:8] == `CCP_PRE_MA_HI)
    else $error("precharge bank or upper address wrong");
  a_pre_one_array: assert property (pre |-> o_sdram.cs_n == sel && in_mode &&
    !i_cpu.write && o_cpu_stretched_clock)
    else $error("precharge outside a stalled mode read or wrong array");
  a_mrs_fields: assert property (mrs |-> o_sdram.cs_n == sel && in_mode && i_cpu.write &&
    o_sdram.bank == 2'h0 && o_sdram.mux_addr == {6'h00, i_cpu.addr[8:2]})
    else $error("mode set fields wrong");
  a_mask_held: assert property (cnt != `CCP_MASK_RELEASE && !cmd |->
    o_sdram.byte_mask == `CCP_MASK_ALL)
    else $error("byte masks released before four commands");
  a_mask_release: assert property ($rose(cnt == `CCP_MASK_RELEASE) |->
    ##[0:2] o_sdram.byte_mask == `CCP_MASK_NONE)
    else $error("byte masks not released after four commands");
endmodule // ccp_front_assertions

bind ccp_front ccp_front_assertions #(.DIV_HALF(DIV_HALF)) u_ccp_front_assertions (
  .i_core_clk(i_core_clk),
  .i_reset_n(i_reset_n),
  .i_cpu(i_cpu),
  .o_cpu_stretched_clock(o_cpu_stretched_clock),
  .o_cpu_data(o_cpu_data),
  .o_cpu_data_oe(o_cpu_data_oe),
  .o_sdram(o_sdram)
);

// ===== verif/cpu_csr_sdram_precharge_front_tb.sv
// Purpose: Self-checking bench of the core bus front end
// Assumes: Divider kept at the default half period of 4 core clocks
// Notes: Expected values come from bench functions, map figures and literals
`timescale 1ns/1ns
`include "ccp_map.svh"
module cpu_csr_sdram_precharge_front_tb;
  localparam int DIVH = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ref_req = 1'b0;
  logic clk_cpu;
  logic [31:0] cpu_d;
  logic cpu_oe;
  logic oe;
  logic [31:0] rdata;
  logic [31:0] v;
  logic [8:0] idx;
  ccp_pkg::ccp_cpu_in_t cpu;
  ccp_pkg::ccp_sdram_t sd;
  ccp_pkg::ccp_sdram_t last;
  ccp_pkg::ccp_word_t push [3];
  ccp_pkg::ccp_word_t pop [3];
  logic [2:0] rdy;
  logic [2:0] pop_rdy = 3'h0;
  int ncmd = 0;
  int c;
  int miscompares = 0;
  int checks = 0;
  int seed = 88642;

  always #25 clk = ~clk;

  ccp_front #(.DIV_HALF(DIVH)) u_ccp_front (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_cpu(cpu), .i_refresh_req(ref_req),
    .o_cpu_stretched_clock(clk_cpu), .o_cpu_data(cpu_d), .o_cpu_data_oe(cpu_oe), .o_sdram(sd),
    .i_ob_push(push[0]), .o_ob_ready(rdy[0]), .i_ob_pop_ready(pop_rdy[0]), .o_ob_pop(pop[0]),
    .i_ib_push(push[1]), .o_ib_ready(rdy[1]), .i_ib_pop_ready(pop_rdy[1]), .o_ib_pop(pop[1]),
    .i_rf_push(push[2]), .o_rf_ready(rdy[2]), .i_rf_pop_ready(pop_rdy[2]), .o_rf_pop(pop[2]));

  ccp_cpu_model u_ccp_cpu_model (
    .i_core_clk(clk), .i_cpu_clk(clk_cpu), .i_data(cpu_d),
    .i_data_oe(cpu_oe), .o_cpu(cpu));

  // Last SDRAM command and a running count of them
  always @(posedge clk) begin
    if (sd.cs_n !== 4'hF) begin
      last <= sd;
      ncmd <= ncmd + 1;
    end
  end

  // ********************
  // Tasks and functions
  // ********************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  task automatic csr(input logic wr, input logic [8:0] i, input logic [31:0] d);
    u_ccp_cpu_model.bus_cycle(wr, {`CCP_CSR_REGION, 13'h0000, i, 2'h0}, d, rdata, oe);
    check("data enable", {31'h0, oe}, {31'h0, ~wr});
  endtask

  // Refresh request, then a bounded wait for any command it brings
  task automatic refresh();
    c = ncmd;
    ref_req <= 1'b1;
    @(posedge clk);
    ref_req <= 1'b0;
    for (int n = 0; n < 20 && ncmd == c; n++) @(posedge clk);
  endtask

  // Command fields without the masks: cs_n, ras_n, cas_n, we_n, bank, mux_addr
  function automatic logic [31:0] exp_cmd(input logic mrs, input logic [1:0] arr,
                                          input logic [6:0] m);
    exp_cmd = {10'h000, ~(4'h1 << arr), 1'b0, ~mrs, 1'b0, mrs ? 2'h0 : 2'h3,
               mrs ? {6'h00, m} : 13'h1F00};
  endfunction

  // Fill until refused while the drain side stalls, then drain at random pace
  task automatic fifo(input int f, input int depth);
    logic [31:0] q [$];
    logic pr;
    for (int n = 0; n < 200; n++) begin
      push[f] <= {1'b1, 32'($random(seed))};
      @(posedge clk);
      if (rdy[f] !== 1'b1) break;
      q.push_back(push[f].data);
    end
    check("fifo words", 32'(q.size()), 32'(depth));
    push[f] <= '0;
    for (int n = 0; n < 2000 && q.size() > 0; n++) begin
      pr = 1'($random(seed));
      pop_rdy[f] <= pr;
      @(posedge clk);
      if (pr && pop[f].valid === 1'b1) check("fifo data", pop[f].data, q.pop_front());
    end
    pop_rdy[f] <= 1'b0;
    check("fifo left", 32'(q.size()), 32'h0);
  endtask

  // ********************
  // Main sequence
  // ********************
  initial begin
    for (int i = 0; i < 3; i++) push[i] = '0;
    do_reset();
    check("mask at reset", {28'h0, sd.byte_mask}, 32'h0000_000F);
    csr(1'b0, `CCP_CSR_CTRL, 32'h0);
    check("ctrl reset", rdata, `CCP_CTRL_RESET);
    csr(1'b0, `CCP_CSR_STAT, 32'h0);
    check("status reset", rdata, 32'h0);
    for (int k = 0; k < 4; k++) begin
      v = $random(seed);
      idx = (k == 0) ? 9'h1FF : 9'($random(seed)) | 9'h002;
      csr(1'b1, `CCP_CSR_CTRL, v);
      csr(1'b1, idx, ~v);
      csr(1'b0, idx, v);
      check("unmapped read", rdata, 32'h0);
      csr(1'b0, `CCP_CSR_CTRL, 32'h0);
      check("ctrl", rdata, v);
    end
    // Software order: one precharge to every slot before any mode set
    for (int a = 0; a < 4; a++) begin
      v = $random(seed);
      u_ccp_cpu_model.bus_cycle(1'b0, {`CCP_MODE_REGION, 2'h0, a[1:0], v[19:0]}, v, rdata, oe);
      check("precharge", {10'h000, last[25:4]}, exp_cmd(1'b0, a[1:0], 7'h00));
      csr(1'b0, `CCP_CSR_STAT, 32'h0);
      check("status", rdata, 32'(a + 1));
      check("mask", {28'h0, sd.byte_mask}, (a < 3) ? 32'hF : 32'h0);
    end
    for (int a = 0; a < 4; a++) begin
      v = $random(seed);
      u_ccp_cpu_model.bus_cycle(1'b1, {`CCP_MODE_REGION, 2'h0, a[1:0], v[19:0]}, ~v, rdata, oe);
      check("mode set", {10'h000, last[25:4]}, exp_cmd(1'b1, a[1:0], v[8:2]));
    end
    // Second reset: refresh only counts when enabled
    do_reset();
    csr(1'b1, `CCP_CSR_CTRL, 32'h0);
    refresh();
    check("refresh off", 32'(ncmd - c), 32'h0);
    csr(1'b1, `CCP_CSR_CTRL, `CCP_CTRL_RESET);
    for (int k = 0; k < 4; k++) begin
      refresh();
      check("refresh cmd", {25'h0, last[25:19]}, 32'h0000_0001);
      csr(1'b0, `CCP_CSR_STAT, 32'h0);
      check("status", rdata, 32'(k + 1));
      check("mask", {28'h0, sd.byte_mask}, (k < 3) ? 32'hF : 32'h0);
    end
    fifo(0, `CCP_OB_BYTES / `CCP_WORD_BYTES);
    fifo(1, `CCP_IB_BYTES / `CCP_WORD_BYTES);
    fifo(2, `CCP_RF_BYTES / `CCP_WORD_BYTES);
    end_of_test();
  end

  // Watchdog well past the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
endmodule // cpu_csr_sdram_precharge_front_tb
